// ---- inc/burst_lane_pkg.sv ----
// constants shared by the burst, pll and lane sideband block
package burst_lane_pkg;
  localparam int NUM_LANES = 4;
  localparam int LANE_BITS = 67;
  localparam int LANE_BUS = NUM_LANES * LANE_BITS;
  localparam int DATA_WORDS = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int BYTES_W = 10;
  // burst codes
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_32 = 4'h1;
  localparam logic [3:0] CODE_64 = 4'h2;
  localparam logic [3:0] CODE_128 = 4'h4;
  localparam logic [3:0] CODE_512 = 4'h8;
  // burst sizes in bytes
  localparam logic [9:0] BYTES_32 = 10'h020;
  localparam logic [9:0] BYTES_64 = 10'h040;
  localparam logic [9:0] BYTES_128 = 10'h080;
  localparam logic [9:0] BYTES_512 = 10'h200;
  // values after reset, then the ecc status bit positions
  localparam logic [9:0] RST_MAX_BYTES = 10'h080;
  localparam logic [9:0] RST_SHORT_BYTES = 10'h020;
  localparam logic [9:0] RST_MIN_BYTES = 10'h000;
  localparam logic [1:0] RST_ECC = 2'h0;
  localparam int ECC_CORR_BIT = 1;
  localparam int ECC_UNCORR_BIT = 0;
endpackage

// ---- hdl/burst_lane_sideband.sv ----
// burst settings, ecc status, pll handshake and lane word path with its fifo
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// word fifo
// ************************************************************
module lane_word_fifo #(
  parameter int WIDTH = 268,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic room_q;
  wire push = wr_valid && room_q;
  wire pop = rd_valid && rd_ready;

  // room is its own flop so write ready leaves straight from a register
  assign count_d = count_q + (AW + 1)'(push) - (AW + 1)'(pop);
  assign wr_ready = room_q;
  assign rd_valid = (count_q != '0);
  assign rd_data = mem_q[rd_ptr_q];

  // storage, no reset needed
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_ptr_q] <= wr_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      room_q <= 1'b1;
    end else begin
      wr_ptr_q <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
      rd_ptr_q <= pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
      count_q <= count_d;
      room_q <= (count_d != (AW + 1)'(DEPTH));
    end
  end
endmodule

// ************************************************************
// sideband top
// ************************************************************
// Operation
// - Maximum burst code 4'b0100 gives 128 bytes, 4'b1000 gives 512 bytes.
// - Short burst code 4'b0001 gives 32 bytes, 4'b0010 gives 64 bytes.
// - With minimum burst in force the short burst bytes take the minimum value, but an illegal short code still rejects the whole set.
// - Minimum code 0 disables enhanced scheduling; 2, 4 select 64, 128; 1 (32) is rejected with 8 data words.
// - Minimum code changes only while transmit idle; applied without a reset.
// - Two-bit ecc status per path: bit 1 correctable, bit 0 uncorrectable.
// - Reset controller asks the transmit pll to power down.
// - Lane words are 67 bits per lane each way; rx valids are per lane, tx lanes share one valid.
module burst_lane_sideband (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [3:0] max_burst_length,
  input wire logic [3:0] short_burst_length,
  input wire logic [3:0] min_burst_length,
  input wire logic tx_idle,
  output logic [9:0] max_burst_bytes,
  output logic [9:0] short_burst_bytes,
  output logic [9:0] min_burst_bytes,
  output logic enhanced_sched,
  output logic burst_code_err,
  input wire logic tx_ecc_corr_evt,
  input wire logic tx_ecc_uncorr_evt,
  input wire logic rx_ecc_corr_evt,
  input wire logic rx_ecc_uncorr_evt,
  input wire logic ecc_clear,
  output logic [1:0] tx_ecc_status,
  output logic [1:0] rx_ecc_status,
  input wire logic tx_pll_locked,
  input wire logic tx_pll_cal_busy,
  input wire logic mac_pll_locked,
  input wire logic pll_pd_req,
  output logic tx_pll_powerdown,
  output logic pll_ready,
  input wire logic [burst_lane_pkg::LANE_BUS-1:0] tx_lane_words,
  input wire logic tx_lane_words_valid,
  output logic tx_lane_words_ready,
  output logic [burst_lane_pkg::LANE_BUS-1:0] tx_pma_data,
  output logic [burst_lane_pkg::NUM_LANES-1:0] tx_pma_valid,
  input wire logic [burst_lane_pkg::LANE_BUS-1:0] rx_pma_data,
  input wire logic [burst_lane_pkg::NUM_LANES-1:0] rx_pma_valid,
  output logic [burst_lane_pkg::LANE_BUS-1:0] rx_lane_words,
  output logic [burst_lane_pkg::NUM_LANES-1:0] rx_lane_words_valid
);
  // code to byte decode, used for all three settings
  function automatic logic [9:0] code_bytes(input logic [3:0] code);
    logic [9:0] b;
    b = '0;
    case (code)
      burst_lane_pkg::CODE_32: b = burst_lane_pkg::BYTES_32;
      burst_lane_pkg::CODE_64: b = burst_lane_pkg::BYTES_64;
      burst_lane_pkg::CODE_128: b = burst_lane_pkg::BYTES_128;
      burst_lane_pkg::CODE_512: b = burst_lane_pkg::BYTES_512;
      default: b = '0;
    endcase
    return b;
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // the codes are quasi-static, so a per-bit two-stage sync is enough;
  // a code that moves during traffic may be seen torn for one cycle
  // no reset: the stages flush to the pin levels while reset is held, so no
  // false code error shows after release
  logic [14:0] pin_meta_q;
  logic [14:0] pin_sync_q;
  always_ff @(posedge clock) begin
    pin_meta_q <= {max_burst_length, short_burst_length, min_burst_length,
                   tx_pll_locked, tx_pll_cal_busy, mac_pll_locked};
    pin_sync_q <= pin_meta_q;
  end
  wire [3:0] max_code = pin_sync_q[14:11];
  wire [3:0] short_code = pin_sync_q[10:7];
  wire [3:0] min_code = pin_sync_q[6:3];
  wire pll_lock_s = pin_sync_q[2];
  wire pll_busy_s = pin_sync_q[1];
  wire mac_lock_s = pin_sync_q[0];

  // ************************************************************
  // burst settings
  // ************************************************************
  wire max_ok = (max_code == burst_lane_pkg::CODE_128) ||
                ((max_code == burst_lane_pkg::CODE_512) && (burst_lane_pkg::DATA_WORDS != 4));
  wire short_ok = (short_code == burst_lane_pkg::CODE_32) ||
                  (short_code == burst_lane_pkg::CODE_64);
  wire min_ok = (min_code == burst_lane_pkg::CODE_OFF) || (min_code == burst_lane_pkg::CODE_64) ||
                (min_code == burst_lane_pkg::CODE_128) || ((min_code == burst_lane_pkg::CODE_32) &&
                (burst_lane_pkg::DATA_WORDS != 8) && (burst_lane_pkg::DATA_WORDS != 16));
  wire half_ok = ({code_bytes(min_code), 1'b0} <= {1'b0, code_bytes(max_code)});
  wire cfg_ok = max_ok && short_ok && min_ok && half_ok;
  wire cfg_load = tx_idle && cfg_ok;
  wire [9:0] min_new = code_bytes(min_code);
  // min burst overrides short burst when enabled
  wire [9:0] short_new = (min_new != '0) ? min_new : code_bytes(short_code);

  // new settings land only while idle; bad codes keep the old values
  always_ff @(posedge clock) begin
    if (!rstn) begin
      max_burst_bytes <= burst_lane_pkg::RST_MAX_BYTES;
      short_burst_bytes <= burst_lane_pkg::RST_SHORT_BYTES;
      min_burst_bytes <= burst_lane_pkg::RST_MIN_BYTES;
      enhanced_sched <= 1'b0;
      burst_code_err <= 1'b0;
    end else begin
      if (cfg_load) begin
        max_burst_bytes <= code_bytes(max_code);
        short_burst_bytes <= short_new;
        min_burst_bytes <= min_new;
        enhanced_sched <= (min_new != '0);
      end
      burst_code_err <= !cfg_ok;
    end
  end

  // ************************************************************
  // ecc status, sticky until cleared, set beats clear
  // ************************************************************
  wire [1:0] tx_ecc_set = {tx_ecc_corr_evt, tx_ecc_uncorr_evt};
  wire [1:0] rx_ecc_set = {rx_ecc_corr_evt, rx_ecc_uncorr_evt};
  always_ff @(posedge clock) begin
    if (!rstn) begin
      tx_ecc_status <= burst_lane_pkg::RST_ECC;
      rx_ecc_status <= burst_lane_pkg::RST_ECC;
    end else begin
      tx_ecc_status <= tx_ecc_set | (ecc_clear ? 2'h0 : tx_ecc_status);
      rx_ecc_status <= rx_ecc_set | (ecc_clear ? 2'h0 : rx_ecc_status);
    end
  end

  // ************************************************************
  // pll handshake
  // ************************************************************
  // the pll is held down through reset so it restarts calibration cleanly
  always_ff @(posedge clock) begin
    if (!rstn) begin
      tx_pll_powerdown <= 1'b1;
      pll_ready <= 1'b0;
    end else begin
      tx_pll_powerdown <= pll_pd_req;
      pll_ready <= pll_lock_s && !pll_busy_s && mac_lock_s && !pll_pd_req;
    end
  end

  // ************************************************************
  // lane words
  // ************************************************************
  logic fifo_valid;
  logic [burst_lane_pkg::LANE_BUS-1:0] fifo_data;
  wire fifo_pop = fifo_valid && pll_ready; // words wait while the pll is not ready

  lane_word_fifo #(
    .WIDTH(burst_lane_pkg::LANE_BUS),
    .DEPTH(burst_lane_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clock(clock),
    .rstn(rstn),
    .wr_valid(tx_lane_words_valid),
    .wr_ready(tx_lane_words_ready),
    .wr_data(tx_lane_words),
    .rd_valid(fifo_valid),
    .rd_ready(pll_ready),
    .rd_data(fifo_data)
  );

  // one 67-bit word per lane each cycle, tx lanes qualified together, rx valids copied per lane
  always_ff @(posedge clock) begin
    if (!rstn) begin
      tx_pma_data <= '0;
      tx_pma_valid <= '0;
      rx_lane_words <= '0;
      rx_lane_words_valid <= '0;
    end else begin
      tx_pma_data <= fifo_pop ? fifo_data : tx_pma_data;
      tx_pma_valid <= {burst_lane_pkg::NUM_LANES{fifo_pop}};
      rx_lane_words <= rx_pma_data;
      rx_lane_words_valid <= rx_pma_valid;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_idle_load;
    tx_idle && cfg_ok;
  endsequence
  sequence s_busy_run;
    !tx_idle [*2];
  endsequence

  property p_max_apply;
    @(posedge clock) disable iff (!rstn)
    s_idle_load |=> (max_burst_bytes == $past(code_bytes(max_code)));
  endproperty
  a_max_apply: assert property (p_max_apply) else $error("max burst not applied");

  property p_max_hold;
    @(posedge clock) disable iff (!rstn)
    s_busy_run |-> $stable(max_burst_bytes);
  endproperty
  a_max_hold: assert property (p_max_hold) else $error("max burst moved in traffic");

  property p_short_legal;
    @(posedge clock) disable iff (!rstn)
    !enhanced_sched |-> (short_burst_bytes == burst_lane_pkg::BYTES_32 ||
                        short_burst_bytes == burst_lane_pkg::BYTES_64);
  endproperty
  a_short_legal: assert property (p_short_legal) else $error("bad short burst");

  property p_short_obsolete;
    @(posedge clock) disable iff (!rstn)
    enhanced_sched |-> (short_burst_bytes == min_burst_bytes);
  endproperty
  a_short_obsolete: assert property (p_short_obsolete) else $error("short not overridden");

  property p_min_off;
    @(posedge clock) disable iff (!rstn)
    (s_idle_load and (min_code == burst_lane_pkg::CODE_OFF)) |=> !enhanced_sched ##0
      (min_burst_bytes == '0);
  endproperty
  a_min_off: assert property (p_min_off) else $error("enhanced scheduling left on");

  property p_min_hold;
    @(posedge clock) disable iff (!rstn)
    !tx_idle |=> $stable(min_burst_bytes) && $stable(enhanced_sched);
  endproperty
  a_min_hold: assert property (p_min_hold) else $error("min burst moved while busy");

  property p_ecc_sticky;
    @(posedge clock) disable iff (!rstn)
    tx_ecc_corr_evt ##1 !ecc_clear [*2] |-> tx_ecc_status[burst_lane_pkg::ECC_CORR_BIT];
  endproperty
  a_ecc_sticky: assert property (p_ecc_sticky) else $error("tx ecc flag lost");

  property p_ecc_set_wins;
    @(posedge clock) disable iff (!rstn)
    (rx_ecc_uncorr_evt && ecc_clear) |=> rx_ecc_status[burst_lane_pkg::ECC_UNCORR_BIT];
  endproperty
  a_ecc_set_wins: assert property (p_ecc_set_wins) else $error("rx ecc set lost to clear");

  property p_powerdown;
    @(posedge clock) disable iff (!rstn)
    pll_pd_req |=> tx_pll_powerdown && !pll_ready;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("pll powerdown not driven");

  property p_lane_word;
    @(posedge clock) disable iff (!rstn)
    fifo_pop |=> (tx_pma_valid == '1) && (tx_pma_data == $past(fifo_data));
  endproperty
  a_lane_word: assert property (p_lane_word) else $error("lane word not issued");
endmodule

`default_nettype wire

// ---- dv/pll_lane_partner.sv ----
// behavioural transmit pll and transceiver lanes facing the sideband block
`timescale 1ns/1ns
`default_nettype none
module pll_lane_partner #(
  parameter int LOCK_CYC = 6
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic hold_lock,
  input wire logic tx_pll_powerdown,
  input wire logic rx_send,
  input wire logic [burst_lane_pkg::LANE_BUS-1:0] rx_word,
  output logic tx_pll_locked,
  output logic tx_pll_cal_busy,
  output logic mac_pll_locked,
  output logic [burst_lane_pkg::LANE_BUS-1:0] rx_pma_data,
  output logic [burst_lane_pkg::NUM_LANES-1:0] rx_pma_valid
);
  logic [7:0] cal_q = 8'h00;
  logic run;
  // hold_lock stands for a slow pll; power-down drops lock at once
  assign run = rstn && !tx_pll_powerdown && !hold_lock;
  always @(posedge clock) begin
    if (!run) begin
      cal_q <= 8'h00;
    end else if (cal_q < 8'(LOCK_CYC)) begin
      cal_q <= cal_q + 8'h01;
    end
  end
  // busy while calibrating, lock only once calibration has ended
  assign tx_pll_cal_busy = run && (cal_q < 8'(LOCK_CYC));
  assign tx_pll_locked = run && (cal_q == 8'(LOCK_CYC));
  assign mac_pll_locked = tx_pll_locked;
  // a released lane toggles its last word each cycle, showing the inverse and then the stale copy again
  initial rx_pma_data = '0;
  initial rx_pma_valid = '0;
  always @(posedge clock) begin
    rx_pma_data <= rx_send ? rx_word : ~rx_pma_data;
    rx_pma_valid <= rx_send ? 4'hf : 4'h0;
  end
endmodule
`default_nettype wire

// ---- dv/tb_burst_lane_sideband.sv ----
// self-checking bench for the burst, pll and lane sideband block
`timescale 1ns/1ns
`default_nettype none
module tb_burst_lane_sideband;
  logic clock, rstn, tx_idle, ecc_clear, pll_pd_req, hold_lock, rx_send, wvalid, wready;
  logic tc, tu, rc, ru, err, enh, pd, rdy, lk, busy, mlk;
  logic [3:0] mx, sh, mn, txv, prv, rxv;
  logic [9:0] mxb, shb, mnb;
  logic [1:0] tes, res;
  logic [burst_lane_pkg::LANE_BUS-1:0] wdata, rx_word, txd, prd, rxd;
  int bad_count, compares;
  burst_lane_sideband burst_lane_sideband_inst (.clock(clock), .rstn(rstn),
    .max_burst_length(mx), .short_burst_length(sh), .min_burst_length(mn), .tx_idle(tx_idle),
    .max_burst_bytes(mxb), .short_burst_bytes(shb), .min_burst_bytes(mnb),
    .enhanced_sched(enh), .burst_code_err(err), .tx_ecc_corr_evt(tc), .tx_ecc_uncorr_evt(tu),
    .rx_ecc_corr_evt(rc), .rx_ecc_uncorr_evt(ru), .ecc_clear(ecc_clear), .tx_ecc_status(tes),
    .rx_ecc_status(res), .tx_pll_locked(lk), .tx_pll_cal_busy(busy), .mac_pll_locked(mlk),
    .pll_pd_req(pll_pd_req), .tx_pll_powerdown(pd), .pll_ready(rdy), .tx_lane_words(wdata),
    .tx_lane_words_valid(wvalid), .tx_lane_words_ready(wready), .tx_pma_data(txd),
    .tx_pma_valid(txv), .rx_pma_data(prd), .rx_pma_valid(prv), .rx_lane_words(rxd),
    .rx_lane_words_valid(rxv));
  pll_lane_partner pll_lane_partner_inst (.clock(clock), .rstn(rstn), .hold_lock(hold_lock),
    .tx_pll_powerdown(pd), .rx_send(rx_send), .rx_word(rx_word), .tx_pll_locked(lk),
    .tx_pll_cal_busy(busy), .mac_pll_locked(mlk), .rx_pma_data(prd), .rx_pma_valid(prv));
  // ******************************************
  // shared tasks
  // ******************************************
  task automatic chk(input string n, input logic [267:0] e, input logic [267:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // inputs always move 5 ns after the edge so no race with the design
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask
  task automatic tally_and_finish();
    $display("counts: compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    for (int i = 0; i < 100 && rdy !== 1'b1; i++) begin
      cyc(1);
    end
    chk("pll_ready", 1'b1, rdy);
    if (rdy !== 1'b1) begin
      tally_and_finish();
    end
  endtask
  // codes pass two sync stages then load on an idle edge: four cycles cover it
  task automatic burst(input logic [3:0] a, b, c, input logic idle, input logic [9:0] ea, eb,
                       ec, input logic ee);
    mx = a;
    sh = b;
    mn = c;
    tx_idle = idle;
    cyc(4);
    chk("max_burst_bytes", ea, mxb);
    chk("short_burst_bytes", eb, shb);
    chk("min_burst_bytes", ec, mnb);
    chk("enhanced_sched", ec != 10'h000, enh);
    chk("burst_code_err", ee, err);
  endtask
  function automatic logic [267:0] word(input int i);
    return {67'(i + 3), 67'(i + 2), 67'(i + 1), 67'(i)};
  endfunction
  // ******************************************
  // scenarios
  // ******************************************
  task automatic test_burst();
    burst(4'h8, 4'h2, 4'h4, 1'b1, 10'h200, 10'h080, 10'h080, 1'b0);
    burst(4'h4, 4'h2, 4'h2, 1'b1, 10'h080, 10'h040, 10'h040, 1'b0);
    burst(4'h4, 4'h2, 4'h0, 1'b1, 10'h080, 10'h040, 10'h000, 1'b0);
    burst(4'h4, 4'h1, 4'h0, 1'b1, 10'h080, 10'h020, 10'h000, 1'b0);
    burst(4'h8, 4'h1, 4'h0, 1'b0, 10'h080, 10'h020, 10'h000, 1'b0);
    // the 512 set held back while busy loads on the first idle edge
    burst(4'h4, 4'h1, 4'h4, 1'b1, 10'h200, 10'h020, 10'h000, 1'b1);
    burst(4'h8, 4'h1, 4'h1, 1'b1, 10'h200, 10'h020, 10'h000, 1'b1);
    burst(4'h3, 4'h1, 4'h0, 1'b1, 10'h200, 10'h020, 10'h000, 1'b1);
    burst(4'h8, 4'h1, 4'h2, 1'b1, 10'h200, 10'h040, 10'h040, 1'b0);
    $display("test burst settings done");
  endtask
  task automatic test_ecc();
    tc = 1'b1;
    ru = 1'b1;
    cyc(1);
    tc = 1'b0;
    ru = 1'b0;
    chk("tx_ecc_status", 2'h2, tes);
    chk("rx_ecc_status", 2'h1, res);
    tu = 1'b1;
    rc = 1'b1;
    cyc(1);
    tu = 1'b0;
    rc = 1'b0;
    chk("tx_ecc_status", 2'h3, tes);
    chk("rx_ecc_status", 2'h3, res);
    cyc(1);
    chk("tx_ecc_status", 2'h3, tes);
    ecc_clear = 1'b1;
    tc = 1'b1;
    ru = 1'b1;
    cyc(1);
    tc = 1'b0;
    ru = 1'b0;
    chk("tx_ecc_status", 2'h2, tes);
    chk("rx_ecc_status", 2'h1, res);
    cyc(1);
    ecc_clear = 1'b0;
    chk("tx_ecc_status", 2'h0, tes);
    chk("rx_ecc_status", 2'h0, res);
    $display("test ecc status done");
  endtask
  task automatic test_pll();
    wait_rdy();
    pll_pd_req = 1'b1;
    cyc(1);
    chk("tx_pll_powerdown", 1'b1, pd);
    chk("pll_ready", 1'b0, rdy);
    pll_pd_req = 1'b0;
    cyc(1);
    chk("tx_pll_powerdown", 1'b0, pd);
    wait_rdy();
    $display("test pll handshake done");
  endtask
  // fill the fifo with the pll held off, then let it drain in order
  task automatic test_tx();
    int k;
    hold_lock = 1'b1;
    cyc(4);
    for (int i = 0; i < 32; i++) begin
      wdata = word(i);
      wvalid = 1'b1;
      k = 0;
      // ready is read settled, after the edge, so the next edge takes the word
      while (wready !== 1'b1 && k < 50) begin
        cyc(1);
        k++;
      end
      if (k == 50) begin
        chk("tx_lane_words_ready", 1'b1, wready);
        tally_and_finish();
      end
      cyc(1);
    end
    wvalid = 1'b0;
    chk("tx_lane_words_ready", 1'b0, wready);
    chk("tx_pma_valid", 4'h0, txv);
    hold_lock = 1'b0;
    k = 0;
    for (int c = 0; c < 300 && k < 32; c++) begin
      cyc(1);
      if (txv !== 4'h0) begin
        chk("tx_pma_valid", 4'hf, txv);
        chk("tx_pma_data", word(k), txd);
        k++;
      end
    end
    chk("tx words drained", 32, k);
    chk("tx_lane_words_ready", 1'b1, wready);
    $display("test tx lanes done");
  endtask
  task automatic test_rx();
    rx_word = word(40);
    rx_send = 1'b1;
    cyc(1);
    rx_word = word(90);
    cyc(1);
    rx_send = 1'b0;
    chk("rx_lane_words", word(40), rxd);
    chk("rx_lane_words_valid", 4'hf, rxv);
    cyc(1);
    chk("rx_lane_words", word(90), rxd);
    cyc(1);
    chk("rx_lane_words_valid", 4'h0, rxv);
    $display("test rx lanes done");
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    {bad_count, compares} = '0;
    {rstn, tx_idle, ecc_clear, pll_pd_req, hold_lock, rx_send, wvalid} = '0;
    {tc, tu, rc, ru} = '0;
    mx = 4'h4;
    sh = 4'h1;
    mn = 4'h0;
    wdata = '0;
    rx_word = '0;
    cyc(6);
    chk("max_burst_bytes", 10'h080, mxb);
    chk("tx_pll_powerdown", 1'b1, pd);
    chk("tx_ecc_status", 2'h0, tes);
    cyc(2);
    rstn = 1'b1;
    cyc(1);
    test_burst();
    test_ecc();
    test_pll();
    test_tx();
    test_rx();
    tally_and_finish();
  end
endmodule
`default_nettype wire
